// ===== sgc_link_gate.sv
// link-down warm reset gating and eeprom-load select for the warm sequence
`timescale 1ns/1ps
module sgc_link_gate
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // controls from the register
  input wire logic linkdown_disable,
  input wire logic skip_eeprom,
  // event from the upstream data link layer
  input wire logic dl_down_event,
  // requests to the reset sequencer
  output logic linkdown_warm_reset,
  output logic warm_reset_eeprom_load
);

  // all state of this module; both outputs come from these flops
  typedef struct packed {
    logic linkdown_warm_reset; // masked link-down request
    logic warm_reset_eeprom_load; // eeprom step kept in warm sequence
  } sgc_gate_state_t;

  sgc_gate_state_t state_r;
  sgc_gate_state_t state_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // only the link-down cause is masked, other causes stay live upstream
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.linkdown_warm_reset = dl_down_event & ~linkdown_disable;
    state_nxt.warm_reset_eeprom_load = ~skip_eeprom;
  end

  // state register; the clock enable freezes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= '0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  assign linkdown_warm_reset = state_r.linkdown_warm_reset;
  assign warm_reset_eeprom_load = state_r.warm_reset_eeprom_load;

endmodule

// ===== sgc_pkg.sv
// constants, field layout and carrier types of the switch global control
package sgc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // address map
  localparam logic [11:0] SGC_ADDR_SWITCH_GLOBAL_CONTROL = 12'h32C;

  ////////////////////////////////////////////////////////////////////////////
  // bit positions inside the register
  localparam int SGC_BIT_FULL_RESET = 0;
  localparam int SGC_BIT_WARM_RESET = 1;
  localparam int SGC_BIT_RESET_HOLD = 2;
  localparam int SGC_BIT_UNLOCK = 3;
  localparam int SGC_BIT_PWR_BUDGET_WE = 4;
  localparam int SGC_BIT_LINKDOWN_DIS = 5;
  localparam int SGC_BIT_SKIP_EEPROM = 6;
  localparam int SGC_BIT_RO_DISABLE = 7;
  localparam int SGC_BIT_PEER_DISABLE = 8;
  localparam int SGC_BIT_CUT_THRU_DIS = 14;
  localparam int SGC_BIT_LOCK_IGNORE = 15;
  localparam int SGC_BIT_WAKE_DIR = 16;
  localparam int SGC_BIT_AUX_PWR_EN = 17;
  localparam int SGC_BIT_BCAST_DROP = 18;

  ////////////////////////////////////////////////////////////////////////////
  // masks and reset values
  // bits that hold storage; trigger bits and reserved bits are not stored
  localparam logic [31:0] SGC_STORE_MASK = 32'h0007C1FC;
  // bits that survive a fundamental reset
  localparam logic [31:0] SGC_FR_KEEP_MASK = 32'h00030000;
  // value after aux power-on, before straps are taken
  localparam logic [31:0] SGC_RESET_VALUE = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite response codes
  localparam logic [1:0] SGC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SGC_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // control outputs carried together to the switch core
  typedef struct packed {
    logic reset_hold;
    logic locked_field_write_enable;
    logic power_budget_write_enable;
    logic linkdown_warm_reset_disable;
    logic skip_eeprom_load_on_warm_reset;
    logic relaxed_ordering_disable;
    logic peer_traffic_disable;
    logic cut_through_disable;
    logic lock_semantics_ignore;
    logic wake_pin_direction;
    logic aux_power_enable;
    logic vendor_broadcast_drop;
  } sgc_ctrl_t;

  // reset sequencing status from the switch core
  typedef struct packed {
    logic full_reset_active;
    logic warm_reset_active;
    logic eeprom_init_error;
    logic dl_down_event;
  } sgc_rst_stat_t;

endpackage

// ===== sgc_properties.sv
// concurrent checks on the switch global control ports
`timescale 1ns/1ps
module sgc_properties
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  // reset sequencing side
  input wire sgc_pkg::sgc_rst_stat_t rst_stat,
  input wire logic full_reset_trigger,
  input wire logic warm_reset_trigger,
  input wire logic linkdown_warm_reset,
  input wire logic warm_reset_eeprom_load,
  input wire logic core_reset_hold,
  // static controls
  input wire sgc_pkg::sgc_ctrl_t ctrl
);
  // one domain, so clock and disable are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // trigger pulses only with a write answer, one cycle wide
  property p_full_pulse;
    full_reset_trigger |-> s_axi_bvalid ##1 !full_reset_trigger;
  endproperty
  a_full_pulse: assert property (p_full_pulse)
    else $error("full reset pulse wrong");
  property p_warm_pulse;
    warm_reset_trigger |-> s_axi_bvalid ##1 !warm_reset_trigger;
  endproperty
  a_warm_pulse: assert property (p_warm_pulse)
    else $error("warm reset pulse wrong");
  // trigger, reserved bits never read back
  property p_rd_zero;
    s_axi_rvalid |-> (s_axi_rdata & 32'hFFF83E03) == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("nonzero trigger or reserved bit read");

  ////////////////////////////////////////////////////////////////////////////
  // hold output follows the stored bit
  property p_hold;
    core_reset_hold == ctrl.reset_hold;
  endproperty
  a_hold: assert property (p_hold)
    else $error("core hold differs from bit");
  property p_init_err;
    ce && rst_stat.eeprom_init_error |=> ctrl.reset_hold && core_reset_hold;
  endproperty
  a_init_err: assert property (p_init_err)
    else $error("init error did not set hold");
  // unlock forced during any reset sequence
  property p_unlock;
    ce && (rst_stat.warm_reset_active || rst_stat.full_reset_active)
      |=> ctrl.locked_field_write_enable;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("unlock not set in reset");
  // power budget unlock only rises while unlocked
  property p_pbw;
    $rose(ctrl.power_budget_write_enable)
      |-> $past(ctrl.locked_field_write_enable);
  endproperty
  a_pbw: assert property (p_pbw)
    else $error("budget unlock written while locked");

  ////////////////////////////////////////////////////////////////////////////
  // link-down warm reset gated, one cycle late
  property p_linkdown;
    ce && aresetn |=> linkdown_warm_reset == ($past(rst_stat.dl_down_event)
      && !$past(ctrl.linkdown_warm_reset_disable));
  endproperty
  a_linkdown: assert property (p_linkdown)
    else $error("link-down warm reset gating wrong");
  property p_eeload;
    ce && aresetn |=> warm_reset_eeprom_load
      == !$past(ctrl.skip_eeprom_load_on_warm_reset);
  endproperty
  a_eeload: assert property (p_eeload)
    else $error("eeprom load select wrong");
  // wake direction and aux power survive a full reset
  property p_fr_keep;
    ce && rst_stat.full_reset_active |=> $stable(ctrl.wake_pin_direction)
      && $stable(ctrl.aux_power_enable);
  endproperty
  a_fr_keep: assert property (p_fr_keep)
    else $error("sticky bits lost in full reset");
endmodule

// ===== sgc_top.sv
// switch global control register with axi4-lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module sgc_top
#(
  parameter int ADDR_W = 12
)
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // straps, sampled at the first enabled edge after reset release
  input wire logic reset_hold_strap,
  input wire logic aux_power_disable_pin_n,
  // reset sequencing status from the switch core
  input wire sgc_pkg::sgc_rst_stat_t rst_stat,
  // reset requests to the sequencer
  output logic full_reset_trigger,
  output logic warm_reset_trigger,
  output logic linkdown_warm_reset,
  output logic warm_reset_eeprom_load,
  // hold of all switch logic except the smbus side
  output logic core_reset_hold,
  // static controls to the switch core
  output sgc_pkg::sgc_ctrl_t ctrl
);

  ////////////////////////////////////////////////////////////////////////////
  // all state of this module, in one struct so that a single register
  // process holds it; the bus side and the register image share the
  // clock enable, so a frozen block never loses half a handshake
  typedef struct packed {
    logic init_done;          // straps taken
    logic [31:0] switch_global_control;       // stored register image
    logic full_trig;          // one-cycle full reset request
    logic warm_trig;          // one-cycle warm reset request
    logic hold;               // copy of reset hold driving the core
    logic awready;
    logic wready;
    logic aw_full;            // write address captured
    logic w_full;             // write data captured
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sgc_state_t;

  // present and next copies of the whole state
  sgc_state_t state_r;
  sgc_state_t state_nxt;

  // handshake terms, decoded from the bus valids and the registered readies, so no
  // bus input reaches an output without passing a flop first
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_write;
  logic write_hit;

  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the read and write paths; the two low
  // address bits are ignored, as every access is one aligned word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    addr_hit = (a[11:2] == sgc_pkg::SGC_ADDR_SWITCH_GLOBAL_CONTROL[11:2]);
  endfunction

  // byte-lane merge; unlock gates the write-when-unlocked bit
  // trigger bits never land in storage, so they always read back zero
  function automatic logic [31:0] merge_write(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] lane;
    logic [31:0] res;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    // reserved and trigger bits never stored
    lane = lane & sgc_pkg::SGC_STORE_MASK;
    // locked field stays put while unlock is clear
    if (!old[sgc_pkg::SGC_BIT_UNLOCK])
    begin
      lane[sgc_pkg::SGC_BIT_PWR_BUDGET_WE] = 1'b0;
    end
    res = (old & ~lane) | (data & lane);
    merge_write = res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // handshakes seen this cycle
  // a beat moves at the rising edge where valid and ready are both high
  assign aw_hs = s_axi_awvalid & state_r.awready;
  assign w_hs = s_axi_wvalid & state_r.wready;
  assign ar_hs = s_axi_arvalid & state_r.arready;
  // the write fires once both halves are held and no answer is pending
  // limitation: one write in flight; a second waits for the response
  assign do_write = state_r.aw_full & state_r.w_full & ~state_r.bvalid;
  assign write_hit = addr_hit(state_r.aw_addr);

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    state_nxt = state_r;
    // trigger outputs are pulses
    // cleared every cycle, so a write sets them for exactly one cycle
    state_nxt.full_trig = 1'b0;
    state_nxt.warm_trig = 1'b0;

    // first enabled cycle after release: take straps, open the bus
    // readies stay low until then so no transfer lands before the straps
    if (!state_r.init_done)
    begin
      state_nxt.init_done = 1'b1;
      // power-on value of aux enable is the inverse of the pin
      state_nxt.switch_global_control[sgc_pkg::SGC_BIT_AUX_PWR_EN] =
        ~aux_power_disable_pin_n;
      state_nxt.switch_global_control[sgc_pkg::SGC_BIT_RESET_HOLD] = reset_hold_strap;
      state_nxt.awready = 1'b1;
      state_nxt.wready = 1'b1;
      state_nxt.arready = 1'b1;
    end

    // capture write address
    // each half is refused again until its response has been taken
    if (aw_hs)
    begin
      state_nxt.aw_addr = s_axi_awaddr;
      state_nxt.aw_full = 1'b1;
      state_nxt.awready = 1'b0;
    end

    // capture write data, either order with the address
    if (w_hs)
    begin
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
      state_nxt.w_full = 1'b1;
      state_nxt.wready = 1'b0;
    end

    // both halves present and the previous answer gone: commit now
    // perform the write and raise the response
    if (do_write)
    begin
      state_nxt.aw_full = 1'b0;
      state_nxt.w_full = 1'b0;
      state_nxt.bvalid = 1'b1;
      if (write_hit)
      begin
        state_nxt.bresp = sgc_pkg::SGC_RESP_OKAY;
        state_nxt.switch_global_control = merge_write(state_r.switch_global_control, state_r.w_data,
          state_r.w_strb);
        // a one starts the reset; a zero does nothing
        if (state_r.w_strb[0] && state_r.w_data[sgc_pkg::SGC_BIT_FULL_RESET])
        begin
          state_nxt.full_trig = 1'b1;
        end
        if (state_r.w_strb[0] && state_r.w_data[sgc_pkg::SGC_BIT_WARM_RESET])
        begin
          state_nxt.warm_trig = 1'b1;
        end
      end
      else
      begin
        // unmapped address: no effect, error answer
        state_nxt.bresp = sgc_pkg::SGC_RESP_SLVERR;
      end
    end

    // response taken: reopen both write channels
    // a new address or data beat is accepted from the next cycle on
    if (state_r.bvalid && s_axi_bready)
    begin
      state_nxt.bvalid = 1'b0;
      state_nxt.awready = 1'b1;
      state_nxt.wready = 1'b1;
    end

    // reset actions come after the bus write on purpose: a write in the
    // same cycle as a reset sequence step loses on the fields that step sets
    // fundamental reset restores defaults except the power-on fields
    if (rst_stat.full_reset_active)
    begin
      state_nxt.switch_global_control = (state_nxt.switch_global_control & sgc_pkg::SGC_FR_KEEP_MASK);
      state_nxt.switch_global_control[sgc_pkg::SGC_BIT_RESET_HOLD] = reset_hold_strap;
    end

    // any reset operation opens locked fields for eeprom loading
    // unlock stays set after the sequence; software locks it again
    if (rst_stat.full_reset_active || rst_stat.warm_reset_active)
    begin
      state_nxt.switch_global_control[sgc_pkg::SGC_BIT_UNLOCK] = 1'b1;
    end

    // init error sets hold; set wins over a clearing write
    // placed after the reset overrides so a failed load always halts
    if (rst_stat.eeprom_init_error)
    begin
      state_nxt.switch_global_control[sgc_pkg::SGC_BIT_RESET_HOLD] = 1'b1;
    end

    // hold follows the bit that will be stored
    // taken from the next value so the core sees hold with the bit itself
    state_nxt.hold = state_nxt.switch_global_control[sgc_pkg::SGC_BIT_RESET_HOLD];

    // read: answer one cycle after the address is taken
    // reads the registered image, so a write in the same cycle is not seen
    if (ar_hs)
    begin
      state_nxt.arready = 1'b0;
      state_nxt.rvalid = 1'b1;
      if (addr_hit(s_axi_araddr))
      begin
        // trigger and reserved bits read zero
        state_nxt.rdata =
          state_r.switch_global_control & sgc_pkg::SGC_STORE_MASK;
        state_nxt.rresp = sgc_pkg::SGC_RESP_OKAY;
      end
      else
      begin
        state_nxt.rdata = 32'h00000000;
        state_nxt.rresp = sgc_pkg::SGC_RESP_SLVERR;
      end
    end

    // read data taken: reopen the read address channel
    if (state_r.rvalid && s_axi_rready)
    begin
      state_nxt.rvalid = 1'b0;
      state_nxt.arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; the clock enable freezes everything
  // reset is taken whether or not the clock enable is high, because it
  // stands for aux power-on and must not be masked by a stalled clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // unlock and wake direction come up clear at power-on
      state_r <= '0;
      state_r.switch_global_control <= sgc_pkg::SGC_RESET_VALUE;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link-down gating and eeprom load select
  // kept in its own module so the sequencer side can be retimed alone
  sgc_link_gate u_link_gate
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .linkdown_disable(state_r.switch_global_control[sgc_pkg::SGC_BIT_LINKDOWN_DIS]),
    .skip_eeprom(state_r.switch_global_control[sgc_pkg::SGC_BIT_SKIP_EEPROM]),
    .dl_down_event(rst_stat.dl_down_event),
    .linkdown_warm_reset(linkdown_warm_reset),
    .warm_reset_eeprom_load(warm_reset_eeprom_load)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs, straight from the state flops
  // no logic after the flops keeps the bus timing independent of decode
  assign s_axi_awready = state_r.awready;
  assign s_axi_wready = state_r.wready;
  assign s_axi_bvalid = state_r.bvalid;
  assign s_axi_bresp = state_r.bresp;
  assign s_axi_arready = state_r.arready;
  assign s_axi_rvalid = state_r.rvalid;
  assign s_axi_rdata = state_r.rdata;
  assign s_axi_rresp = state_r.rresp;

  // reset requests
  // triggers are one-cycle pulses; a held level would restart a sequence
  assign full_reset_trigger = state_r.full_trig;
  assign warm_reset_trigger = state_r.warm_trig;
  assign core_reset_hold = state_r.hold;

  ////////////////////////////////////////////////////////////////////////////
  // static controls; each field is a stored bit of the register
  // these fields steer the core; here the unlock bit also gates the budget
  // write-enable, and the link-down and skip-eeprom bits feed u_link_gate
  assign ctrl.reset_hold = state_r.switch_global_control[sgc_pkg::SGC_BIT_RESET_HOLD];
  assign ctrl.locked_field_write_enable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_UNLOCK];
  assign ctrl.power_budget_write_enable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_PWR_BUDGET_WE];
  assign ctrl.linkdown_warm_reset_disable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_LINKDOWN_DIS];
  assign ctrl.skip_eeprom_load_on_warm_reset =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_SKIP_EEPROM];
  assign ctrl.relaxed_ordering_disable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_RO_DISABLE];
  assign ctrl.peer_traffic_disable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_PEER_DISABLE];
  assign ctrl.cut_through_disable =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_CUT_THRU_DIS];
  assign ctrl.lock_semantics_ignore =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_LOCK_IGNORE];
  // one means the wake pin is driven by the switch
  assign ctrl.wake_pin_direction =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_WAKE_DIR];
  assign ctrl.aux_power_enable = state_r.switch_global_control[sgc_pkg::SGC_BIT_AUX_PWR_EN];
  assign ctrl.vendor_broadcast_drop =
    state_r.switch_global_control[sgc_pkg::SGC_BIT_BCAST_DROP];

endmodule

// ===== switch_global_control_tb_top.sv
// self-checking bench for the switch global control register
`timescale 1ns/1ps
module switch_global_control_tb_top;
  localparam logic [11:0] A = sgc_pkg::SGC_ADDR_SWITCH_GLOBAL_CONTROL;
  localparam logic [1:0] OK = sgc_pkg::SGC_RESP_OKAY;
  localparam logic [1:0] ER = sgc_pkg::SGC_RESP_SLVERR;
  // design inputs, all valued at time zero
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic reset_hold_strap = 1'b0, aux_power_disable_pin_n = 1'b1;
  sgc_pkg::sgc_rst_stat_t rst_stat = '0;
  // design outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, full_reset_trigger, warm_reset_trigger;
  logic linkdown_warm_reset, warm_reset_eeprom_load, core_reset_hold;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  sgc_pkg::sgc_ctrl_t ctrl;
  // expectations: write {triggers, resp}, read {resp, data}
  logic [3:0] bq[$];
  logic [33:0] rq[$];
  logic [3:0] eb;
  logic [33:0] er;
  logic [31:0] em, d;
  logic [3:0] s;
  int fail_count = 0;
  int check_count = 0;

  always #4 aclk = ~aclk;

  sgc_top u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .reset_hold_strap, .aux_power_disable_pin_n, .rst_stat,
    .full_reset_trigger, .warm_reset_trigger, .linkdown_warm_reset,
    .warm_reset_eeprom_load, .core_reset_hold, .ctrl);

  ////////////////////////////////////////////////////////////////////////////
  // reference: stored bits per lane, budget unlock needs old unlock
  function automatic logic [31:0] upd(input logic [31:0] o,
    input logic [31:0] v, input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    m = m & sgc_pkg::SGC_STORE_MASK;
    if (!o[3])
      m[4] = 1'b0;
    return (o & ~m) | (v & m);
  endfunction

  // controls expected from a register value
  function automatic sgc_pkg::sgc_ctrl_t cx(input logic [31:0] e);
    return {e[2], e[3], e[4], e[5], e[6], e[7], e[8], e[14], e[15],
      e[16], e[17], e[18]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // closing verdict
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic miss(input string m);
    fail_count++;
    $display("MISMATCH at %0t: %s", $time, m);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // write: address and data offered together, bready held until answer
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
    input logic [3:0] st, input logic [1:0] r);
    logic ta, tw, tb;
    bq.push_back({(a == A && st[0]) ? {v[0], v[1]} : 2'b00, r});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    // look at mid-cycle what the next edge will take
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [1:0] r);
    logic t;
    rq.push_back({r, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = s_axi_rvalid;
      @(posedge aclk);
    end
    s_axi_rready <= 1'b0;
  endtask

  // one-cycle reset status pulse; bit 3 full, 2 warm, 1 init error
  task automatic pulse(input int k);
    @(posedge aclk);
    rst_stat <= sgc_pkg::sgc_rst_stat_t'(4'h1 << k);
    @(posedge aclk);
    rst_stat <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // monitor: handshakes seen mid-cycle, oldest note compared
  always @(negedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
    begin
      eb = bq.pop_front();
      check_count++;
      if ({full_reset_trigger, warm_reset_trigger, s_axi_bresp} !== eb)
        miss("write answer");
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      er = rq.pop_front();
      check_count++;
      if ({s_axi_rresp, s_axi_rdata} !== er) miss("read data");
      // controls and reset-side outputs settle with the stored image
      if (er[33:32] == OK && ctrl !== cx(er[31:0])) miss("ctrl");
      if (er[33:32] == OK && core_reset_hold !== er[2]) miss("hold");
      if (er[33:32] == OK && warm_reset_eeprom_load !== !er[6])
        miss("eeprom load");
    end
  end

  // watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge aclk);
    miss("timeout");
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(50));
    aux_power_disable_pin_n <= 1'($urandom);
    do_reset();
    em = 32'h0;
    em[17] = ~aux_power_disable_pin_n;
    rd(A, em, OK);
    wr(A, 32'hFFFFFFFF, 4'hF, OK);
    em = upd(em, 32'hFFFFFFFF, 4'hF);
    rd(A, em, OK);
    wr(A, 32'h00000008, 4'h1, OK);
    em = upd(em, 32'h8, 4'h1);
    wr(A, 32'h00000019, 4'h1, OK);
    em = upd(em, 32'h19, 4'h1);
    rd(A, em, OK);
    // random values and strobes, link-down events meanwhile
    for (int i = 0; i < 12; i++)
    begin
      d = $urandom;
      s = 4'($urandom);
      rst_stat.dl_down_event <= 1'($urandom);
      wr(A, d, s, OK);
      em = upd(em, d, s);
      rd(A, em, OK);
    end
    rst_stat <= '0;
    wr(12'h330, 32'hFFFFFFFF, 4'hF, ER);
    rd(12'h330, 32'h0, ER);
    rd(A, em, OK);
    // clock enable low: an init error pulse must leave the image alone
    ce <= 1'b0;
    pulse(1);
    ce <= 1'b1;
    rd(A, em, OK);
    pulse(1);
    em[2] = 1'b1;
    rd(A, em, OK);
    pulse(2);
    em[3] = 1'b1;
    rd(A, em, OK);
    pulse(3);
    em = (em & 32'h00030000) | 32'h00000008;
    rd(A, em, OK);
    // second power-on with the disable pin flipped
    aux_power_disable_pin_n <= ~aux_power_disable_pin_n;
    do_reset();
    em = 32'h0;
    em[17] = ~aux_power_disable_pin_n;
    rd(A, em, OK);
    print_verdict();
  end
endmodule

bind sgc_top sgc_properties u_props (.aclk, .aresetn, .ce, .s_axi_bvalid,
  .s_axi_rvalid, .s_axi_rdata, .rst_stat, .full_reset_trigger,
  .warm_reset_trigger, .linkdown_warm_reset, .warm_reset_eeprom_load,
  .core_reset_hold, .ctrl);
